// ---- quadword_system_bus_master.sv ----
`timescale 1ns/10ps
`include "qsb_cfg.svh"
// How it works
// RQ1: bursts move four quadwords, else one
// RQ2: hold address until address acknowledge
// RQ3: size code 00 single, 11 burst
// RQ4: bus error on missing address/data answer
// RQ5: bus error abandons current cycle; code runs data phase after address error, restarts burst before last beat
// RQ6: bus error sets fetch or data exception; code sets one only on data-phase errors
// RQ7: dma returns bus and interrupts after error
// RQ8: processor default owner, request/grant idle in reset
// RQ9: master starts on grant, drops request last
// RQ10: data phases follow address phase order
// RQ11: dma wins simultaneous contention
// RQ12: drop grant after last address acknowledge
// RQ13: release request on full buffer or read
// RQ14: release request drops with grant
// RQ15: master finishes then drops request
// RQ16: at most two outstanding address phases
// RQ17: data strobe one cycle before data
// RQ18: first write quadword after data strobe
// RQ19: read data sampled cycle after acknowledge
// RQ20: next write quadword after each acknowledge
// RQ21: slave gives four acknowledges per burst
// RQ22: burst completes in five cycles fastest
// RQ23: single read completes in two cycles fastest
// RQ24: address phase ends cycle after acknowledge
// RQ25: non-pipelined slave delays address acknowledge
// RQ26: address strobe active one cycle only
// RQ27: end address phase after acknowledge sampled
// RQ28: no third request while two outstanding
module quadword_system_bus_master
  import qsb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire qsb_pkg::req_s req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [127:0] wdata,
  output logic wdata_next,
  output logic [127:0] rdata,
  output logic rdata_valid,
  output logic done,
  input wire logic [7:0] wbb_fill_bytes,
  input wire logic read_pending,
  output qsb_pkg::addr_bus_s addr_bus,
  output logic master_addr_strobe_n,
  output logic master_data_phase_strobe_n,
  output logic [127:0] master_write_bus,
  input wire logic addr_acknowledge_n,
  input wire logic data_acknowledge_n,
  input wire logic [127:0] system_data_bus,
  input wire logic bus_error_n,
  input wire logic external_bus_request_n,
  output logic bus_grant_n,
  output logic bus_release_request_n,
  output logic err_data_q,
  output logic err_ifetch_q
);
  import qsb_pkg::*;

  localparam int unsigned OUTST = 2;

  // two-entry queue of address phases awaiting data phases
  req_s que_q [OUTST];
  logic [1:0] cnt_q;
  logic head_q;
  logic aphase_q;
  req_s cur_q;
  logic ack_seen_q;
  logic dphase_q;
  logic dstart_q;
  logic [2:0] beats_q;
  logic owner_cpu;
  logic addr_done;
  logic push;
  logic pop;
  logic dack;
  logic [2:0] outstanding;
  logic rd_take_q;
  logic wr_step_q;
  arb_e arb_q;

  function automatic logic [2:0] beats_of(input logic burst);
    beats_of = burst ? `QSB_BURST_BEATS : 3'h1; // see RQ1
  endfunction

  assign owner_cpu = (arb_q == ARB_CPU);
  assign dack = !data_acknowledge_n;
  // acknowledge or bus error closes the address phase
  assign addr_done = aphase_q && !ack_seen_q && (!addr_acknowledge_n || !bus_error_n); // see RQ4
  assign push = req_valid && req_ready;
  assign pop = dphase_q && (beats_q == 3'h1) && (dack || !bus_error_n);
  // phases left after this edge, before any new request is counted
  assign outstanding = {1'b0, cnt_q} + {2'h0, addr_done} - {2'h0, pop};

  // issue: one address phase at a time, at most two outstanding
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      req_ready <= 1'b0;
      master_addr_strobe_n <= 1'b1;
      aphase_q <= 1'b0;
      ack_seen_q <= 1'b0;
      cur_q <= '0;
      addr_bus <= '0;
    end
    else
    begin
      master_addr_strobe_n <= 1'b1; // see RQ26
      req_ready <= 1'b0;
      if (push)
      begin
        cur_q <= req;
        aphase_q <= 1'b1;
        ack_seen_q <= 1'b0;
        master_addr_strobe_n <= 1'b0;
        addr_bus.addr <= req.addr;
        addr_bus.byte_en <= req.byte_en;
        addr_bus.rd_n <= req.write;
        addr_bus.wr_n <= !req.write;
        addr_bus.tsize <= req.burst ? `QSB_TSIZE_BURST : `QSB_TSIZE_SINGLE; // see RQ3
      end
      else if (addr_done)
        ack_seen_q <= 1'b1; // see RQ2
      else if (ack_seen_q)
      begin
        aphase_q <= 1'b0; // see RQ24 RQ27
        ack_seen_q <= 1'b0;
      end
      // a pending dma request keeps the processor off the bus, see RQ11
      if (!push && owner_cpu && external_bus_request_n && (!aphase_q || addr_done) &&
          req_valid && !req_ready)
        req_ready <= (outstanding < 3'(OUTST)); // see RQ16 RQ28
    end
  end

  // ordered queue of accepted address phases
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_q <= '0;
      head_q <= 1'b0;
      que_q[0] <= '0;
      que_q[1] <= '0;
    end
    else
    begin
      // new entry goes into the slot after the oldest one still waiting
      if (addr_done)
        que_q[1'(head_q + cnt_q[0] - (pop ? 1'b0 : 1'b0))] <= cur_q; // see RQ10
      if (pop)
        head_q <= !head_q;
      cnt_q <= cnt_q + (addr_done ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
    end
  end

  // data phase: strobe, then count acknowledges
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dphase_q <= 1'b0;
      dstart_q <= 1'b0;
      beats_q <= '0;
      master_data_phase_strobe_n <= 1'b1;
    end
    else
    begin
      master_data_phase_strobe_n <= 1'b1;
      dstart_q <= 1'b0;
      if (!dphase_q && cnt_q != 2'h0 && owner_cpu)
      begin
        dphase_q <= 1'b1;
        dstart_q <= 1'b1;
        master_data_phase_strobe_n <= 1'b0; // see RQ17
        beats_q <= beats_of(que_q[head_q].burst);
      end
      // acknowledges count from the strobe cycle on, for the fastest slaves
      else if (dphase_q)
      begin
        if (!bus_error_n)
          dphase_q <= 1'b0; // see RQ5
        else if (dack)
        begin
          beats_q <= beats_q - 3'h1; // see RQ21 RQ22
          if (beats_q == 3'h1)
            dphase_q <= 1'b0;
        end
      end
    end
  end

  // write data out, read data in; both act one cycle after the acknowledge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      master_write_bus <= '0;
      wdata_next <= 1'b0;
      rdata <= '0;
      rdata_valid <= 1'b0;
      done <= 1'b0;
      wr_step_q <= 1'b0;
      rd_take_q <= 1'b0;
    end
    else
    begin
      wdata_next <= 1'b0;
      rdata_valid <= 1'b0;
      done <= pop && bus_error_n;
      // the slave captures a quadword the cycle after acknowledging it
      wr_step_q <= dphase_q && dack && bus_error_n && que_q[head_q].write && beats_q != 3'h1;
      // read data stand on the bus the cycle after the acknowledge
      rd_take_q <= dphase_q && dack && bus_error_n && !que_q[head_q].write;
      if (dstart_q && que_q[head_q].write)
      begin
        master_write_bus <= wdata; // see RQ18
        wdata_next <= 1'b1;
      end
      else if (wr_step_q)
      begin
        master_write_bus <= wdata; // see RQ20
        wdata_next <= 1'b1;
      end
      if (rd_take_q)
      begin
        rdata <= system_data_bus; // see RQ19 RQ23
        rdata_valid <= 1'b1;
      end
    end
  end

  // exception flags for processor cycles
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      err_data_q <= 1'b0;
      err_ifetch_q <= 1'b0;
    end
    // only a data-phase error of a processor cycle raises an exception
    else if (dphase_q && !bus_error_n && owner_cpu)
    begin
      if (que_q[head_q].ifetch)
        err_ifetch_q <= 1'b1; // see RQ6
      else
        err_data_q <= 1'b1;
    end
  end

  // arbiter: dma priority, cycle stealing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      arb_q <= ARB_CPU;
      bus_grant_n <= 1'b1; // see RQ8
      bus_release_request_n <= 1'b1;
    end
    else
    begin
      case (arb_q)
        ARB_CPU:
          // grant only while the processor has nothing on the bus
          if (!external_bus_request_n && !aphase_q && !push && !req_ready && cnt_q == 2'h0)
          begin
            arb_q <= ARB_DMA; // see RQ11
            bus_grant_n <= 1'b0;
          end
        ARB_DMA:
          if (external_bus_request_n && !addr_acknowledge_n)
          begin
            arb_q <= ARB_CPU; // see RQ12
            bus_grant_n <= 1'b1;
          end
          else if (wbb_fill_bytes > `QSB_WBB_STEAL_BYTES || read_pending)
          begin
            arb_q <= ARB_STEAL; // see RQ13
            bus_release_request_n <= 1'b0;
          end
        ARB_STEAL:
          if (external_bus_request_n && !addr_acknowledge_n)
          begin
            arb_q <= ARB_CPU;
            bus_grant_n <= 1'b1;
            bus_release_request_n <= 1'b1; // see RQ14
          end
        default:
        begin
          arb_q <= ARB_CPU;
          bus_grant_n <= 1'b1;
          bus_release_request_n <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ---- qsb_cfg.svh ----
`ifndef QSB_CFG_SVH
`define QSB_CFG_SVH
`define QSB_TSIZE_SINGLE 2'h0
`define QSB_TSIZE_BURST 2'h3
`define QSB_BURST_BEATS 3'h4
`define QSB_WBB_STEAL_BYTES 8'h40
`endif

// ---- qsb_pkg.sv ----
package qsb_pkg;
  typedef struct packed {
    logic [27:0] addr;
    logic [15:0] byte_en;
    logic write;
    logic burst;
    logic ifetch;
  } req_s;
  typedef struct packed {
    logic [27:0] addr;
    logic [15:0] byte_en;
    logic rd_n;
    logic wr_n;
    logic [1:0] tsize;
  } addr_bus_s;
  typedef enum logic [1:0] {
    ARB_CPU = 2'b00,
    ARB_DMA = 2'b01,
    ARB_STEAL = 2'b11
  } arb_e;
endpackage

// ---- qsb_monitor.sv ----
`timescale 1ns/10ps
module qsb_monitor
  import qsb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire qsb_pkg::addr_bus_s addr_bus,
  input wire logic master_addr_strobe_n,
  input wire logic addr_acknowledge_n,
  input wire logic data_acknowledge_n,
  input wire logic bus_error_n,
  input wire logic external_bus_request_n,
  input wire logic bus_grant_n,
  input wire logic bus_release_request_n,
  input wire logic rdata_valid,
  input wire logic err_ifetch_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_astrobe_width: assert property (!master_addr_strobe_n |=> master_addr_strobe_n)
    else $error("addr strobe too long");
  a_addr_hold: assert property (!master_addr_strobe_n && addr_acknowledge_n |=> $stable(addr_bus))
    else $error("addr moved before ack");
  a_size_code: assert property (!master_addr_strobe_n |-> addr_bus.tsize inside {2'h0, 2'h3})
    else $error("bad size code");
  a_reset_idle: assert property ($past(sys_rst) |-> bus_grant_n && bus_release_request_n)
    else $error("arbiter active after reset");
  a_release_drop: assert property ($rose(bus_release_request_n) |-> $rose(bus_grant_n))
    else $error("release not with grant");
  a_grant_cause: assert property ($fell(bus_grant_n) |-> $past(!external_bus_request_n))
    else $error("grant without request");
  a_release_owner: assert property (!bus_release_request_n |-> !bus_grant_n)
    else $error("release while owner");
  a_read_sample: assert property (rdata_valid |-> $past(!data_acknowledge_n, 2))
    else $error("read data without ack");
  a_error_cause: assert property ($rose(err_ifetch_q) |-> $past(!bus_error_n))
    else $error("fetch error without bus error");
endmodule

// ---- qsb_slave_model.sv ----
`timescale 1ns/10ps
module qsb_slave_model
  import qsb_pkg::*;
(
  input wire logic clk,
  input wire logic mute,
  input wire logic dma_ack,
  input wire qsb_pkg::addr_bus_s addr_bus,
  input wire logic master_addr_strobe_n,
  input wire logic master_data_phase_strobe_n,
  input wire logic [127:0] master_write_bus,
  output logic addr_acknowledge_n = 1'b1,
  output logic data_acknowledge_n = 1'b1,
  output logic [127:0] system_data_bus = '0
);
  int beats_q[$];
  logic [127:0] wr_q[$];
  int left = 0;
  int go = 0;
  logic [7:0] n = 8'h0;
  logic took = 1'b0;
  always @(posedge clk)
  begin
    addr_acknowledge_n <= !dma_ack;
    system_data_bus <= ~system_data_bus;
    took <= !data_acknowledge_n;
    if (took)
      wr_q.push_back(master_write_bus);
    if (!data_acknowledge_n)
    begin
      system_data_bus <= {16{n}};
      n <= n + 8'h1;
    end
    if (!master_addr_strobe_n && !mute)
    begin
      addr_acknowledge_n <= 1'b0; // pipelined slave, acks at once
      beats_q.push_back(addr_bus.tsize == 2'h3 ? 4 : 1);
    end
    if (!master_data_phase_strobe_n)
      go++;
    if (mute)
      go = 0;
    if (left == 0 && go > 0 && beats_q.size() > 0)
    begin
      left = beats_q.pop_front();
      go--;
    end
    data_acknowledge_n <= (left == 0);
    if (left > 0)
      left--;
  end
endmodule

// ---- quadword_system_bus_master_bench.sv ----
`timescale 1ns/10ps
module quadword_system_bus_master_bench;
  import qsb_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  req_s req = '0;
  logic req_valid = 1'b0;
  logic [127:0] wdata = '0;
  logic [7:0] wbb_fill_bytes = 8'h0;
  logic read_pending = 1'b0;
  logic bus_error_n = 1'b1;
  logic external_bus_request_n = 1'b1;
  logic mute = 1'b0;
  logic dma_ack = 1'b0;
  logic req_ready, wdata_next, rdata_valid, done, master_addr_strobe_n;
  logic master_data_phase_strobe_n, addr_acknowledge_n, data_acknowledge_n;
  logic bus_grant_n, bus_release_request_n, err_data_q, err_ifetch_q;
  logic [127:0] rdata, master_write_bus, system_data_bus, b;
  addr_bus_s addr_bus;
  logic [7:0] nr;
  int err_count = 0;
  int n_compared = 0;
  int i;
  quadword_system_bus_master DUT (.clk, .sys_rst, .req, .req_valid, .req_ready, .wdata,
    .wdata_next, .rdata, .rdata_valid, .done, .wbb_fill_bytes, .read_pending, .addr_bus,
    .master_addr_strobe_n, .master_data_phase_strobe_n, .master_write_bus, .addr_acknowledge_n,
    .data_acknowledge_n, .system_data_bus, .bus_error_n, .external_bus_request_n, .bus_grant_n,
    .bus_release_request_n, .err_data_q, .err_ifetch_q);
  qsb_slave_model slave (.clk, .mute, .dma_ack, .addr_bus, .master_addr_strobe_n,
    .master_data_phase_strobe_n, .master_write_bus, .addr_acknowledge_n, .data_acknowledge_n,
    .system_data_bus);
  initial forever #20 clk = ~clk;
  always @(posedge clk)
  begin
    #1;
    if (wdata_next)
      wdata = wdata + 128'h1;
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic await(ref logic f, input logic v);
    for (int k = 0; k < 200 && f !== v; k++)
      tick(1);
    if (f !== v)
    begin
      err_count++;
      conclude();
    end
  endtask
  task automatic issue(input logic w, input logic s, input logic f);
    req = '{addr: 28'h0001230, byte_en: 16'hffff, write: w, burst: s, ifetch: f};
    req_valid = 1'b1;
    await(req_ready, 1'b1);
    tick(1);
  endtask
  task automatic reads(input int cnt);
    repeat (cnt)
    begin
      await(rdata_valid, 1'b1);
      check(rdata, {16{nr}});
      nr++;
      tick(1);
    end
  endtask
  task automatic sc_reads;
    nr = slave.n;
    fork
      reads(5);
      begin
        issue(1'b0, 1'b1, 1'b0);
        issue(1'b0, 1'b0, 1'b0);
        req_valid = 1'b0;
      end
    join
  endtask
  task automatic sc_writes;
    slave.wr_q.delete();
    b = wdata;
    issue(1'b1, 1'b1, 1'b0);
    issue(1'b1, 1'b0, 1'b0);
    req_valid = 1'b0;
    for (i = 0; i < 100 && slave.wr_q.size() < 5; i++)
      tick(1);
    check(slave.wr_q.size(), 5);
    for (i = 0; i < slave.wr_q.size(); i++)
      check(slave.wr_q[i], b + i);
  endtask
  task automatic sc_error;
    bus_error_n = 1'b0;
    tick(1);
    bus_error_n = 1'b1;
    check({err_ifetch_q, err_data_q}, 2'b00);
    for (i = 1; i >= 0; i--)
    begin
      mute = 1'b1;
      issue(1'b0, 1'b0, i[0]);
      req_valid = 1'b0;
      tick(6);
      bus_error_n = 1'b0; // address phase gets no answer
      tick(1);
      bus_error_n = 1'b1;
      await(master_data_phase_strobe_n, 1'b0);
      tick(2);
      bus_error_n = 1'b0;
      tick(1);
      check(done, 1'b0);
      bus_error_n = 1'b1;
      tick(2);
      mute = 1'b0;
      check({err_ifetch_q, err_data_q}, {1'b1, !i[0]});
    end
    sc_reads();
  endtask
  task automatic sc_dma;
    external_bus_request_n = 1'b0;
    await(bus_grant_n, 1'b0);
    req = '{addr: 28'h0004560, byte_en: 16'hffff, write: 1'b0, burst: 1'b0, ifetch: 1'b0};
    req_valid = 1'b1;
    wbb_fill_bytes = 8'h40;
    tick(4);
    check({req_ready, bus_release_request_n}, 2'b01);
    wbb_fill_bytes = 8'h41;
    await(bus_release_request_n, 1'b0);
    external_bus_request_n = 1'b1;
    tick(3);
    check(bus_grant_n, 1'b0);
    dma_ack = 1'b1;
    tick(1);
    dma_ack = 1'b0;
    await(bus_grant_n, 1'b1);
    check(bus_release_request_n, 1'b1);
    wbb_fill_bytes = 8'h0;
    nr = slave.n;
    await(req_ready, 1'b1);
    tick(1);
    req_valid = 1'b0;
    reads(1);
  endtask
  initial
  begin
    tick(15);
    check({bus_grant_n, bus_release_request_n}, 2'b11);
    tick(1);
    sys_rst = 1'b0;
    tick(2);
    sc_reads();
    sc_writes();
    sc_error();
    sc_dma();
    conclude();
  end
endmodule
bind quadword_system_bus_master qsb_monitor mon (.clk, .sys_rst, .addr_bus,
  .master_addr_strobe_n, .addr_acknowledge_n, .data_acknowledge_n, .bus_error_n,
  .external_bus_request_n, .bus_grant_n, .bus_release_request_n, .rdata_valid, .err_ifetch_q);
